// *** rtl/clock_chip_config_regs_low.sv ***
/*
 Low configuration register bank of the dual-loop clock generator:
 serial port setup, readback select, customer version, input loop
 reference dividers. Assumes a serial port front end that presents
 one decoded byte access per cycle, synchronous to core_clk.
*/
`timescale 1ns/100ps
`include "config_regs_cfg.svh"

module clock_chip_config_regs_low
	import config_regs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic i2c_mode,
	input wire reg_access_t access,
	output logic [7:0] rdata,
	output logic rvalid,
	output logic sdo_enable,
	output logic lsb_first,
	output logic readback_active,
	output logic soft_reset_busy,
	output logic [15:0] customer_version,
	output logic [9:0] reference_a_input_div,
	output logic [9:0] reference_b_input_div,
	output logic [5:0] test_ref_div
);

	config_state_t cfg;
	logic serial_out_on;
	logic order_lsb;
	logic rb_active;
	logic [15:0] version;
	logic [9:0] div_a;
	logic [9:0] div_b;
	logic [5:0] div_test;
	reset_state_t rst_state;
	logic [7:0] next_rdata;
	logic hit;
	logic cfg_write;
	logic soft_reset_req;

	function automatic logic wr_at(input reg_access_t a,
		input logic [11:0] target);
		wr_at = a.wr && (a.addr == target);
	endfunction : wr_at

	// Either mirrored soft reset bit asks for a reset in both modes
	assign soft_reset_req = wr_at(access, `ADDR_SERIAL_PORT_CONFIG) &&
		(access.wdata[`BIT_SOFT_RESET_HI] ||
		access.wdata[`BIT_SOFT_RESET_LO]); // [RULE4] [RULE5] [RULE11]

	// Writes are dropped while a soft reset is in flight
	assign cfg_write = access.wr && (rst_state == ST_RUN) && !soft_reset_req;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rst_state <= ST_RUN;
		end else begin
			unique case (rst_state)
				ST_RUN:
					if (soft_reset_req)
						rst_state <= ST_SOFT_RESET; // [RULE11]
				ST_SOFT_RESET:
					rst_state <= ST_RUN; // [RULE11]
				default:
					rst_state <= ST_RUN;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || rst_state == ST_SOFT_RESET) begin // [RULE11]
			serial_out_on <= 1'b0;
			order_lsb <= 1'b0;
		end else if (cfg_write && !i2c_mode && // [RULE5]
			access.addr == `ADDR_SERIAL_PORT_CONFIG) begin
			// Either mirror position sets the feature
			serial_out_on <= access.wdata[`BIT_OUT_ENABLE_HI] ||
				access.wdata[`BIT_OUT_ENABLE_LO]; // [RULE4]
			order_lsb <= access.wdata[`BIT_ORDER_HI] ||
				access.wdata[`BIT_ORDER_LO]; // [RULE4]
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || rst_state == ST_SOFT_RESET) begin // [RULE11]
			rb_active <= 1'b0;
			version <= `RESET_VERSION;
			div_a <= `RESET_REF_DIV;
			div_b <= `RESET_REF_DIV;
			div_test <= `RESET_TEST_DIV;
		end else if (cfg_write) begin
			// Unlisted addresses take the empty default arm and leave state alone
			unique case (access.addr) // [RULE1]
				`ADDR_READBACK_SELECT:
					rb_active <=
						access.wdata[`BIT_READBACK_ACTIVE]; // [RULE6]
				`ADDR_CUSTOMER_VERSION_LOW:
					version[7:0] <= access.wdata; // [RULE7]
				`ADDR_CUSTOMER_VERSION_HIGH:
					version[15:8] <= access.wdata; // [RULE7]
				`ADDR_REF_A_DIVIDER_LOW:
					div_a[7:0] <= access.wdata; // [RULE8]
				`ADDR_REF_A_DIVIDER_HIGH:
					div_a[9:8] <= access.wdata[1:0]; // [RULE8]
				`ADDR_REF_B_DIVIDER_LOW:
					div_b[7:0] <= access.wdata; // [RULE9]
				`ADDR_REF_B_DIVIDER_HIGH:
					div_b[9:8] <= access.wdata[1:0]; // [RULE9]
				`ADDR_TEST_REF_DIVIDER:
					div_test <= access.wdata[5:0]; // [RULE10]
				default: begin
				end
			endcase
		end
	end

	// Separate flops keep each process the sole writer of what it owns
	assign cfg = '{
		sdo_enable: serial_out_on,
		lsb_first: order_lsb,
		readback_active: rb_active,
		customer_version: version,
		ref_a_div: div_a,
		ref_b_div: div_b,
		test_ref_div: div_test
	};

	config_read_mux u_read_mux (
		.addr(access.addr),
		.i2c_mode(i2c_mode),
		.cfg(cfg),
		.rdata(next_rdata),
		.hit(hit)
	);

	// Unmapped reads answer zero so the host never sees stale bytes
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdata <= `RESET_BYTE;
			rvalid <= 1'b0;
		end else begin
			rvalid <= access.rd;
			rdata <= (access.rd && hit) ? next_rdata : `RESET_BYTE;
		end
	end

	assign sdo_enable = cfg.sdo_enable;
	assign lsb_first = cfg.lsb_first;
	assign readback_active = cfg.readback_active;
	assign customer_version = cfg.customer_version;
	assign reference_a_input_div = cfg.ref_a_div;
	assign reference_b_input_div = cfg.ref_b_div;
	assign test_ref_div = cfg.test_ref_div;
	assign soft_reset_busy = (rst_state == ST_SOFT_RESET);

endmodule : clock_chip_config_regs_low

// *** rtl/config_regs_cfg.svh ***
/*
 Register offsets, field positions and reset values of the low
 configuration register bank. Assumes 12-bit byte addresses, 8-bit data.
*/
// How it works
// RULE1 - Writes to unmapped addresses change nothing
// RULE2 - Host never alters reserved registers
// RULE3 - Host writes defaults into reserved bits
// RULE4 - SPI config mirrors enable, order, reset pairs
// RULE5 - I2C config: only soft reset bits work
// RULE6 - Readback select at bit 0 only
// RULE7 - Sixteen-bit customer version across two bytes
// RULE8 - Ten-bit reference A divider across two bytes
// RULE9 - Ten-bit reference B divider across two bytes
// RULE10 - Six-bit test reference divider field
// RULE11 - Soft reset restores defaults, then self-clears
`ifndef CONFIG_REGS_CFG_SVH
`define CONFIG_REGS_CFG_SVH

`define ADDR_SERIAL_PORT_CONFIG 12'h000
`define ADDR_READBACK_SELECT 12'h004
`define ADDR_CUSTOMER_VERSION_LOW 12'h005
`define ADDR_CUSTOMER_VERSION_HIGH 12'h006
`define ADDR_REF_A_DIVIDER_LOW 12'h010
`define ADDR_REF_A_DIVIDER_HIGH 12'h011
`define ADDR_REF_B_DIVIDER_LOW 12'h012
`define ADDR_REF_B_DIVIDER_HIGH 12'h013
`define ADDR_TEST_REF_DIVIDER 12'h014

`define BIT_OUT_ENABLE_HI 7
`define BIT_ORDER_HI 6
`define BIT_SOFT_RESET_HI 5
`define BIT_SOFT_RESET_LO 2
`define BIT_ORDER_LO 1
`define BIT_OUT_ENABLE_LO 0
`define BIT_READBACK_ACTIVE 0
`define TEST_DIV_WIDTH 6
`define REF_DIV_WIDTH 10

`define RESET_BYTE 8'h00
`define RESET_REF_DIV 10'h000
`define RESET_TEST_DIV 6'h00
`define RESET_VERSION 16'h0000

`endif

// *** rtl/config_regs_pkg.sv ***
/*
 Types shared by the configuration register bank.
 Assumes the cfg header supplies all numeric constants.
*/
package config_regs_pkg;

	typedef struct packed {
		logic sdo_enable;
		logic lsb_first;
		logic readback_active;
		logic [15:0] customer_version;
		logic [9:0] ref_a_div;
		logic [9:0] ref_b_div;
		logic [5:0] test_ref_div;
	} config_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [7:0] wdata;
	} reg_access_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_SOFT_RESET = 2'b10
	} reset_state_t;

endpackage : config_regs_pkg

// *** rtl/config_read_mux.sv ***
/*
 Read data multiplexer for the configuration register bank.
 Assumes state fields already hold their committed values.
*/
`timescale 1ns/100ps
`include "config_regs_cfg.svh"

module config_read_mux
	import config_regs_pkg::*;
(
	input wire logic [11:0] addr,
	input wire logic i2c_mode,
	input wire config_state_t cfg,
	output logic [7:0] rdata,
	output logic hit
);

	always_comb begin
		rdata = `RESET_BYTE;
		hit = 1'b1;
		unique case (addr)
			`ADDR_SERIAL_PORT_CONFIG: begin
				// Soft reset positions read zero; reset clears itself
				if (!i2c_mode) begin // [RULE4] [RULE5]
					rdata[`BIT_OUT_ENABLE_HI] = cfg.sdo_enable;
					rdata[`BIT_OUT_ENABLE_LO] = cfg.sdo_enable;
					rdata[`BIT_ORDER_HI] = cfg.lsb_first;
					rdata[`BIT_ORDER_LO] = cfg.lsb_first;
				end
			end
			`ADDR_READBACK_SELECT:
				rdata[`BIT_READBACK_ACTIVE] = cfg.readback_active; // [RULE6]
			`ADDR_CUSTOMER_VERSION_LOW:
				rdata = cfg.customer_version[7:0]; // [RULE7]
			`ADDR_CUSTOMER_VERSION_HIGH:
				rdata = cfg.customer_version[15:8]; // [RULE7]
			`ADDR_REF_A_DIVIDER_LOW:
				rdata = cfg.ref_a_div[7:0]; // [RULE8]
			`ADDR_REF_A_DIVIDER_HIGH:
				rdata[1:0] = cfg.ref_a_div[9:8]; // [RULE8]
			`ADDR_REF_B_DIVIDER_LOW:
				rdata = cfg.ref_b_div[7:0]; // [RULE9]
			`ADDR_REF_B_DIVIDER_HIGH:
				rdata[1:0] = cfg.ref_b_div[9:8]; // [RULE9]
			`ADDR_TEST_REF_DIVIDER:
				rdata[5:0] = cfg.test_ref_div; // [RULE10]
			default:
				hit = 1'b0;
		endcase
	end

endmodule : config_read_mux

// *** testbench/host_model.sv ***
/* Host model: byte write and read tasks on the access port.
 Assumes read data is settled one cycle after the read is taken. */
`timescale 1ns/100ps
module host_model
	import config_regs_pkg::*;
(
	input wire logic core_clk,
	input wire logic [7:0] rdata,
	output reg_access_t access
);
	initial access = '0;
	// Reserved bits go out at their zero default unless raw is set
	function automatic logic [7:0] keep(logic [11:0] a);
		case (a)
			12'h000: keep = 8'he7;
			12'h004: keep = 8'h01;
			12'h011, 12'h013: keep = 8'h03;
			12'h014: keep = 8'h3f;
			default: keep = 8'hff;
		endcase
	endfunction : keep
	// Only mapped or unused addresses, never reserved ones
	task automatic wr(logic [11:0] a, logic [7:0] d, bit raw);
		@(posedge core_clk);
		access <= '{1'b1, 1'b0, a, raw ? d : d & keep(a)};
		@(posedge core_clk);
		access <= '{1'b0, 1'b0, ~a, ~d};
	endtask : wr
	task automatic rd(logic [11:0] a, output logic [7:0] d);
		@(posedge core_clk);
		access <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge core_clk);
		access <= '{1'b0, 1'b0, ~a, 8'h5a};
		#1 d = rdata;
	endtask : rd
endmodule : host_model

// *** testbench/regs_sva.sv ***
/* Checker for the low config bank ports.
 Assumes one clock and a synchronous active low reset. */
`timescale 1ns/100ps
module regs_sva
	import config_regs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic i2c_mode,
	input wire reg_access_t access,
	input wire logic sdo_enable,
	input wire logic lsb_first,
	input wire logic readback_active,
	input wire logic soft_reset_busy,
	input wire logic [15:0] customer_version,
	input wire logic [9:0] reference_a_input_div,
	input wire logic [9:0] reference_b_input_div,
	input wire logic [5:0] test_ref_div
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic w;
	logic [11:0] a;
	logic [7:0] d, pd;
	logic [44:0] all;
	assign w = access.wr && !soft_reset_busy;
	assign a = access.addr;
	assign d = access.wdata;
	assign all = {sdo_enable, lsb_first, readback_active, customer_version,
		reference_a_input_div, reference_b_input_div, test_ref_div};
	always_ff @(posedge core_clk) pd <= d;
	property p_skip; w && a == 12'h007 |=> $stable(all); endproperty
	a_skip: assert property (p_skip) else $error("unused write");
	property p_mir; w && a == 0 && !i2c_mode && !d[5] && !d[2] |=>
		sdo_enable == (pd[7] | pd[0]) && lsb_first == (pd[6] | pd[1]);
	endproperty
	a_mir: assert property (p_mir) else $error("mirror pair");
	property p_i2c; w && a == 0 && i2c_mode && !d[5] && !d[2] |=>
		$stable({sdo_enable, lsb_first}); endproperty
	a_i2c: assert property (p_i2c) else $error("i2c config");
	property p_rbk; w && a == 12'h004 |=> readback_active == pd[0]; endproperty
	a_rbk: assert property (p_rbk) else $error("readback");
	property p_ver; w && a == 12'h006 |=> customer_version[15:8] == pd;
	endproperty
	a_ver: assert property (p_ver) else $error("version");
	property p_ra; w && a == 12'h011 |=> reference_a_input_div[9:8] == pd[1:0];
	endproperty
	a_ra: assert property (p_ra) else $error("ref a high");
	property p_rb; w && a == 12'h012 |=> reference_b_input_div[7:0] == pd;
	endproperty
	a_rb: assert property (p_rb) else $error("ref b low");
	property p_tst; w && a == 12'h014 |=> test_ref_div == pd[5:0]; endproperty
	a_tst: assert property (p_tst) else $error("test div");
	property p_srst; w && a == 0 && (d[5] || d[2]) |=>
		soft_reset_busy ##1 !soft_reset_busy && all == 0; endproperty
	a_srst: assert property (p_srst) else $error("soft reset");
endmodule : regs_sva

// *** testbench/tb.sv ***
/* Bench for the low config bank: reset values, random writes with readback,
 unused address, I2C mode and soft reset. Assumes host_model drives access. */
`timescale 1ns/100ps
module tb;
	import config_regs_pkg::*;
	logic core_clk = 0, rst_n = 0, i2c_mode = 0;
	reg_access_t access;
	logic [7:0] rdata, q;
	logic rvalid;
	logic [7:0] sh [logic [11:0]];
	logic [11:0] am [9] = '{12'h0, 12'h4, 12'h5, 12'h6, 12'h10, 12'h11,
		12'h12, 12'h13, 12'h14};
	int num_errors = 0, n_compared = 0;
	always #5 core_clk = ~core_clk;
	host_model host(.core_clk(core_clk), .rdata(rdata), .access(access));
	clock_chip_config_regs_low dut(.core_clk(core_clk), .rst_n(rst_n),
		.i2c_mode(i2c_mode), .access(access), .rdata(rdata), .rvalid(rvalid),
		.sdo_enable(), .lsb_first(), .readback_active(), .soft_reset_busy(),
		.customer_version(), .reference_a_input_div(),
		.reference_b_input_div(), .test_ref_div());
	task automatic chk(logic [7:0] s, e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("Error %0t: got %h want %h", $time, s, e);
		end
	endtask : chk
	function automatic logic [7:0] fold(logic [11:0] a, logic [7:0] d);
		logic e, o;
		e = d[7] | d[0];
		o = d[6] | d[1];
		return a == 0 ? {e, o, 4'h0, o, e} : d;
	endfunction : fold
	task automatic all_rd;
		foreach (am[i]) begin
			host.rd(am[i], q);
			chk(q, sh[am[i]]);
		end
	endtask : all_rd
	task automatic close_out;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : close_out
	initial begin
		#100000;
		num_errors++;
		close_out();
	end
	initial begin
		logic [11:0] a;
		logic [7:0] d;
		void'($urandom(54));
		foreach (am[i]) sh[am[i]] = 8'h00;
		repeat (12) @(posedge core_clk);
		rst_n <= 1;
		all_rd();
		$display("test reset done");
		repeat (60) begin
			a = am[$urandom_range(8)];
			d = 8'($urandom);
			if (a == 0) d &= 8'hdb;
			host.wr(a, d, 0);
			sh[a] = fold(a, d & host.keep(a));
		end
		// One bit of the enable and order pairs must light both positions
		host.wr(12'h000, 8'h41, 0);
		sh[0] = fold(0, 8'h41);
		host.wr(12'h007, 8'hff, 0);
		host.rd(12'h007, q);
		chk(q, 8'h00);
		chk({7'h00, rvalid}, 8'h01);
		all_rd();
		$display("test random done");
		i2c_mode <= 1;
		// Reserved bits go out at default; the SPI fields must survive
		host.wr(12'h000, 8'h00, 0);
		host.rd(12'h000, q);
		chk(q, 8'h00);
		i2c_mode <= 0;
		host.rd(12'h000, q);
		chk(q, sh[0]);
		for (int k = 0; k < 2; k++) begin
			host.wr(12'h010, 8'ha5, 0);
			i2c_mode <= !k;
			host.wr(12'h000, k ? 8'h04 : 8'h20, 0);
			foreach (am[i]) sh[am[i]] = 8'h00;
			all_rd();
		end
		$display("test soft reset done");
		close_out();
	end
endmodule : tb
bind clock_chip_config_regs_low regs_sva u_sva(.core_clk(core_clk),
	.rst_n(rst_n), .i2c_mode(i2c_mode), .access(access),
	.sdo_enable(sdo_enable), .lsb_first(lsb_first),
	.readback_active(readback_active), .soft_reset_busy(soft_reset_busy),
	.customer_version(customer_version),
	.reference_a_input_div(reference_a_input_div),
	.reference_b_input_div(reference_b_input_div),
	.test_ref_div(test_ref_div));
